/* verif/sso_enc_model.sv */
// Behavioural external encoder: quadrature lines and one serial line.
// Assumes the bench spaces its step requests and steers the serial wire.
`default_nettype none
module sso_enc_model (
  input wire logic clk_i,
  input wire logic serial_i,
  input wire logic step_i,
  input wire logic up_i,
  input wire logic index_i,
  input wire logic ser_bit_i,
  output logic a_o,
  output logic b_o,
  output logic z_o,
  output logic ser_o
);
  logic [1:0] ph = 2'h0;
  always @(posedge clk_i) begin
    if (step_i && !serial_i) begin
      ph <= up_i ? ph + 2'h1 : ph - 2'h1;
    end
  end
  // Gray order 00,01,11,10: one line moves per step.
  // The quadrature side stays quiet while serial is chosen.
  assign a_o = serial_i ? 1'b0 : ph[1];
  assign b_o = serial_i ? 1'b0 : ph[1] ^ ph[0];
  assign z_o = !serial_i && index_i;
  // A serial line with no encoder behind it idles high, so any leak of
  // it into the receive path shows at the checks.
  assign ser_o = serial_i ? ser_bit_i : 1'b1;
endmodule
`default_nettype wire

/* verif/sso_top_bench.sv */
// Self-checking bench for the status flag and encoder steering block.
// Assumes the design package, the top module and the encoder model.
`default_nettype none
module sso_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  sso_pkg::sso_state_t st = '0;
  logic signed [15:0] cmd = '0, mot = '0, mv, dv;
  logic [15:0] thr = '0, wid = '0;
  logic [2:0] ws1 = '0, ws2 = '0;
  logic [3:0] os [4] = '{default: '0};
  logic [1:0] typ = '0;
  logic stp = 1'b0, up = 1'b0, zi = 1'b0, sb = 1'b0, etx = 1'b0, eten = 1'b0;
  logic mtx = 1'b0, mten = 1'b0, mrx = 1'b0, en, a, b, z, ms;
  logic e_pair, e_oe, m_pair, m_oe, idx, erx, mrxo;
  sso_pkg::sso_flags_t flags;
  logic [3:0] term;
  logic signed [31:0] pos;
  logic [31:0] n;
  int num_errors = 0;
  int num_checks = 0;

  sso_enc_model sso_enc_model_inst (.clk_i(clk_i), .serial_i(typ == 2'h1
    || typ == 2'h2), .step_i(stp), .up_i(up), .index_i(zi),
    .ser_bit_i(sb), .a_o(a), .b_o(b), .z_o(z), .ser_o(ms));
  sso_top sso_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .state_i(st),
    .cmd_speed_i(cmd), .motor_speed_i(mot), .zero_speed_threshold_i(thr),
    .speed_match_width_i(wid), .warning_select_one_i(ws1),
    .warning_select_two_i(ws2), .output_select_first_i(os[0]),
    .output_select_2_i(os[1]), .output_select_3_i(os[2]),
    .output_select_last_i(os[3]), .ext_encoder_type_select_i(typ),
    .ext_enc_phase_a_i(a), .ext_enc_phase_b_i(b), .ext_enc_phase_z_i(z),
    .ext_enc_serial_pair_i(e_oe ? e_pair : ms), .ext_ser_tx_data_i(etx),
    .ext_ser_tx_en_i(eten), .motor_enc_serial_pair_i(m_oe ? m_pair : mrx),
    .motor_ser_tx_data_i(mtx), .motor_ser_tx_en_i(mten), .flags_o(flags),
    .term_o(term), .ext_pos_o(pos), .ext_index_o(idx),
    .ext_ser_rx_o(erx), .ext_enc_serial_pair_o(e_pair),
    .ext_enc_serial_pair_oe_o(e_oe), .motor_ser_rx_o(mrxo),
    .motor_enc_serial_pair_o(m_pair),
    .motor_enc_serial_pair_oe_o(m_oe));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic go;
    @(posedge clk_i);
    #1;
  endtask

  function automatic logic [8:0] ef();
    logic signed [16:0] m, d;
    m = mot;
    if (m < 0) m = -m;
    d = cmd - mot;
    if (d < 0) d = -d;
    return {st.torque_limit_active, m <= thr, d <= wid,
      st.warn_cond[ws1], st.warn_cond[ws2], st.pos_cmd_in,
      st.torque_mode | st.speed_limit_active,
      st.alarm_present | st.alarm_clearable,
      st.speed_mode | st.speed_cmd_in};
  endfunction

  task automatic quad(input logic u);
    @(posedge clk_i);
    stp <= 1'b1;
    up <= u;
    @(posedge clk_i);
    stp <= 1'b0;
    // Steps are spaced no closer than the legal edge spacing.
    repeat (sso_pkg::QUAD_EDGE_CYC) @(posedge clk_i);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    chk(term, 4'h0);
    rstn_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      st <= 16'h1 << i;
      ws1 <= 3'(i);
      ws2 <= 3'(i + i % 2);
      go;
      chk(flags, ef());
    end
    $display("flag sources done");
    @(posedge clk_i);
    st <= '0;
    thr <= 16'h0064;
    wid <= 16'h0032;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      mv = 16'sd100 + 16'(i % 2);
      dv = 16'sd50 + 16'(i / 4 % 2);
      if (i / 2 % 2) mv = -mv;
      if (i / 8) dv = -dv;
      mot <= mv;
      cmd <= mv + dv;
      go;
      chk(flags, ef());
    end
    $display("speed bounds done");
    @(posedge clk_i);
    st <= 16'ha5c3;
    for (int s = 0; s < 16; s++) begin
      @(posedge clk_i);
      for (int k = 0; k < 4; k++) os[k] <= 4'(s + k);
      go;
      for (int k = 0; k < 4; k++) begin
        en = (os[k] >= 4'h1 && os[k] <= 4'h9) ?
            1'(ef() >> (9 - os[k])) : 1'b0;
        chk(term[k], en);
      end
    end
    $display("routing done");
    repeat (10) quad(1'b1);
    repeat (3) quad(1'b0);
    go;
    chk(pos, 32'h7);
    @(posedge clk_i);
    zi <= 1'b1;
    n = '0;
    repeat (6) begin
      go;
      n = n + idx;
    end
    chk(n, 32'h1);
    @(posedge clk_i);
    zi <= 1'b0;
    $display("quadrature done");
    for (int t = 0; t < 4; t++) begin
      @(posedge clk_i);
      typ <= 2'(t);
      {eten, etx, mten, mtx, sb} <= 5'h1e;
      go;
      en = t == 1 || t == 2;
      chk({e_oe, e_pair, m_oe, m_pair}, {en, en, 2'h3});
      @(posedge clk_i);
      {eten, mten, sb, mrx} <= 4'h3;
      go;
      chk({e_oe, e_pair, m_oe, m_pair}, 4'h0);
      go;
      chk({erx, mrxo}, {en, 1'b1});
    end
    $display("serial steering done");
    end_sim;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire

/* verilog/sso_pkg.sv */
// Package for the servo status output block: selector codes, widths,
// encoder type codes and timing constants.
// Assumes a single 250 MHz control clock shared by every user.
`default_nettype none
package sso_pkg;
  localparam int SPD_W = 16;
  localparam int TRQ_W = 16;
  localparam int POS_W = 32;
  localparam int NUM_TERM = 4;
  localparam int WSEL_W = 3;
  localparam int OSEL_W = 4;
  localparam int CLK_MHZ = 250;
  // Least edge spacing and least Z index pulse width of the quadrature input, ns.
  localparam int QUAD_EDGE_NS = 250;
  localparam int QUAD_Z_NS = 1000;
  localparam int QUAD_EDGE_CYC = (QUAD_EDGE_NS * CLK_MHZ + 999) / 1000;
  localparam int QUAD_Z_CYC = (QUAD_Z_NS * CLK_MHZ + 999) / 1000;

  // Output selector codes; zero routes nothing.
  localparam logic [OSEL_W-1:0] SEL_NONE = 4'h0;
  localparam logic [OSEL_W-1:0] SEL_TLIM = 4'h1;
  localparam logic [OSEL_W-1:0] SEL_ZSPD = 4'h2;
  localparam logic [OSEL_W-1:0] SEL_VMATCH = 4'h3;
  localparam logic [OSEL_W-1:0] SEL_WARNING_FLAG_ONE = 4'h4;
  localparam logic [OSEL_W-1:0] SEL_WARNING_FLAG_TWO = 4'h5;
  localparam logic [OSEL_W-1:0] SEL_PCMD = 4'h6;
  localparam logic [OSEL_W-1:0] SEL_VLIM = 4'h7;
  localparam logic [OSEL_W-1:0] SEL_ALMATB = 4'h8;
  localparam logic [OSEL_W-1:0] SEL_VCMD = 4'h9;
  localparam logic [OSEL_W-1:0] OSEL_RESET = 4'h0;

  localparam logic [1:0] ENC_QUAD = 2'h0;
  localparam logic [1:0] ENC_SER_INC = 2'h1;
  localparam logic [1:0] ENC_SER_ABS = 2'h2;

  typedef struct packed {
    logic torque_limited;
    logic zero_speed;
    logic speed_match;
    logic warn_one;
    logic warn_two;
    logic pos_cmd;
    logic speed_limiting;
    logic alarm_attr;
    logic speed_cmd;
  } sso_flags_t;

  typedef struct packed {
    logic torque_limit_active;
    logic speed_limit_active;
    logic torque_mode;
    logic speed_mode;
    logic pos_cmd_in;
    logic speed_cmd_in;
    logic alarm_present;
    logic alarm_clearable;
    logic [7:0] warn_cond;
  } sso_state_t;
endpackage
`default_nettype wire

/* verilog/sso_top.sv */
// Status flag generator with output routing and external encoder input
// steering. Inputs are synchronous to clk_i; speeds are signed two's
// complement, thresholds unsigned magnitudes.
`default_nettype none

module sso_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire sso_pkg::sso_state_t state_i,
  input wire logic signed [sso_pkg::SPD_W-1:0] cmd_speed_i,
  input wire logic signed [sso_pkg::SPD_W-1:0] motor_speed_i,
  input wire logic [sso_pkg::SPD_W-1:0] zero_speed_threshold_i,
  input wire logic [sso_pkg::SPD_W-1:0] speed_match_width_i,
  input wire logic [sso_pkg::WSEL_W-1:0] warning_select_one_i,
  input wire logic [sso_pkg::WSEL_W-1:0] warning_select_two_i,
  input wire logic [sso_pkg::OSEL_W-1:0] output_select_first_i,
  input wire logic [sso_pkg::OSEL_W-1:0] output_select_2_i,
  input wire logic [sso_pkg::OSEL_W-1:0] output_select_3_i,
  input wire logic [sso_pkg::OSEL_W-1:0] output_select_last_i,
  input wire logic [1:0] ext_encoder_type_select_i,
  input wire logic ext_enc_phase_a_i,
  input wire logic ext_enc_phase_b_i,
  input wire logic ext_enc_phase_z_i,
  input wire logic ext_enc_serial_pair_i,
  input wire logic ext_ser_tx_data_i,
  input wire logic ext_ser_tx_en_i,
  input wire logic motor_enc_serial_pair_i,
  input wire logic motor_ser_tx_data_i,
  input wire logic motor_ser_tx_en_i,
  output sso_pkg::sso_flags_t flags_o,
  output logic [sso_pkg::NUM_TERM-1:0] term_o,
  output logic signed [sso_pkg::POS_W-1:0] ext_pos_o,
  output logic ext_index_o,
  output logic ext_ser_rx_o,
  output logic ext_enc_serial_pair_o,
  output logic ext_enc_serial_pair_oe_o,
  output logic motor_ser_rx_o,
  output logic motor_enc_serial_pair_o,
  output logic motor_enc_serial_pair_oe_o
);

  function automatic logic pick_flag(input logic [sso_pkg::OSEL_W-1:0] sel,
                                     input sso_pkg::sso_flags_t f);
    logic r;
    r = 1'b0;
    unique case (sel)
      sso_pkg::SEL_TLIM: r = f.torque_limited;
      sso_pkg::SEL_ZSPD: r = f.zero_speed;
      sso_pkg::SEL_VMATCH: r = f.speed_match;
      sso_pkg::SEL_WARNING_FLAG_ONE: r = f.warn_one;
      sso_pkg::SEL_WARNING_FLAG_TWO: r = f.warn_two;
      sso_pkg::SEL_PCMD: r = f.pos_cmd;
      sso_pkg::SEL_VLIM: r = f.speed_limiting;
      sso_pkg::SEL_ALMATB: r = f.alarm_attr;
      sso_pkg::SEL_VCMD: r = f.speed_cmd;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [sso_pkg::SPD_W:0] mag(
      input logic signed [sso_pkg::SPD_W:0] v);
    return v[sso_pkg::SPD_W] ? (sso_pkg::SPD_W+1)'(-v) : v;
  endfunction

  // Flags and terminals are computed from this cycle's inputs and
  // registered once, so every output lags its cause by exactly one edge.
  sso_pkg::sso_flags_t next_flags;
  logic [sso_pkg::NUM_TERM-1:0] next_term;
  logic [sso_pkg::OSEL_W-1:0] osel [sso_pkg::NUM_TERM];
  logic [sso_pkg::SPD_W:0] speed_abs;
  logic [sso_pkg::SPD_W:0] err_abs;

  assign osel[0] = output_select_first_i;
  assign osel[1] = output_select_2_i;
  assign osel[2] = output_select_3_i;
  assign osel[3] = output_select_last_i;

  always_comb begin
    speed_abs = mag({motor_speed_i[sso_pkg::SPD_W-1], motor_speed_i});
    err_abs = mag((sso_pkg::SPD_W+1)'(
                  {cmd_speed_i[sso_pkg::SPD_W-1], cmd_speed_i} -
                  {motor_speed_i[sso_pkg::SPD_W-1], motor_speed_i}));
    next_flags.torque_limited = state_i.torque_limit_active;
    next_flags.zero_speed =
        speed_abs <= {1'b0, zero_speed_threshold_i};
    next_flags.speed_match =
        err_abs <= {1'b0, speed_match_width_i};
    next_flags.warn_one = state_i.warn_cond[warning_select_one_i];
    next_flags.warn_two = state_i.warn_cond[warning_select_two_i];
    next_flags.pos_cmd = state_i.pos_cmd_in;
    next_flags.speed_limiting =
        state_i.torque_mode | state_i.speed_limit_active;
    next_flags.alarm_attr =
        state_i.alarm_present | state_i.alarm_clearable;
    next_flags.speed_cmd = state_i.speed_mode | state_i.speed_cmd_in;
  end

  for (genvar t = 0; t < sso_pkg::NUM_TERM; t++) begin : g_term
    // Routing uses the fresh flag so a terminal never lags its flag.
    always_comb begin
      next_term[t] = pick_flag(osel[t], next_flags);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_o <= '0;
      term_o <= '0;
    end else begin
      flags_o <= next_flags;
      term_o <= next_term;
    end
  end

  // Quadrature decoder: each A or B edge counts one step, giving the
  // fourfold resolution. At 250 MHz an edge spacing of 250 ns is many
  // cycles, so sampling without a filter keeps up with the rate.
  logic [1:0] ab_q;
  logic [1:0] next_ab_q;
  logic z_q;
  logic next_z_q;
  logic signed [sso_pkg::POS_W-1:0] next_pos;
  logic next_index;
  logic quad_sel;
  logic ser_sel;

  always_comb begin
    quad_sel = ext_encoder_type_select_i == sso_pkg::ENC_QUAD;
    ser_sel = ext_encoder_type_select_i == sso_pkg::ENC_SER_INC ||
              ext_encoder_type_select_i == sso_pkg::ENC_SER_ABS;
    next_ab_q = {ext_enc_phase_a_i, ext_enc_phase_b_i};
    next_z_q = ext_enc_phase_z_i;
    next_pos = ext_pos_o;
    next_index = 1'b0;
    if (quad_sel) begin
      // Gray step direction: forward when the old A differs from new B.
      if (ab_q != next_ab_q && (ab_q ^ next_ab_q) != 2'h3) begin
        if (ab_q[1] ^ next_ab_q[0]) begin
          next_pos = ext_pos_o + 32'sh1;
        end else begin
          next_pos = ext_pos_o - 32'sh1;
        end
      end
      next_index = next_z_q & ~z_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ab_q <= 2'h0;
      z_q <= 1'b0;
      ext_pos_o <= '0;
      ext_index_o <= 1'b0;
    end else begin
      ab_q <= next_ab_q;
      z_q <= next_z_q;
      ext_pos_o <= next_pos;
      ext_index_o <= next_index;
    end
  end

  // Serial pairs: the line driver is enabled only while the serial
  // engine transmits; the external pair also needs a serial type
  // selected, since a quadrature encoder must not see a driven pair.
  logic next_ext_rx;
  logic next_ext_d;
  logic next_ext_oe;
  logic next_mot_rx;
  logic next_mot_d;
  logic next_mot_oe;

  always_comb begin
    next_ext_oe = ser_sel & ext_ser_tx_en_i;
    next_ext_d = next_ext_oe & ext_ser_tx_data_i;
    next_ext_rx = ser_sel & ext_enc_serial_pair_i;
    next_mot_oe = motor_ser_tx_en_i;
    next_mot_d = motor_ser_tx_en_i & motor_ser_tx_data_i;
    next_mot_rx = motor_enc_serial_pair_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_ser_rx_o <= 1'b0;
      ext_enc_serial_pair_o <= 1'b0;
      ext_enc_serial_pair_oe_o <= 1'b0;
      motor_ser_rx_o <= 1'b0;
      motor_enc_serial_pair_o <= 1'b0;
      motor_enc_serial_pair_oe_o <= 1'b0;
    end else begin
      ext_ser_rx_o <= next_ext_rx;
      ext_enc_serial_pair_o <= next_ext_d;
      ext_enc_serial_pair_oe_o <= next_ext_oe;
      motor_ser_rx_o <= next_mot_rx;
      motor_enc_serial_pair_o <= next_mot_d;
      motor_enc_serial_pair_oe_o <= next_mot_oe;
    end
  end

  a_tlim_follow: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    flags_o.torque_limited == $past(state_i.torque_limit_active))
    else $error("torque limited flag wrong");
  a_zero_speed: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (motor_speed_i == '0) |=> flags_o.zero_speed)
    else $error("zero speed flag missing");
  a_zspd_clear: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (!motor_speed_i[sso_pkg::SPD_W-1] &&
      $unsigned(motor_speed_i) > zero_speed_threshold_i)
      |=> !flags_o.zero_speed)
    else $error("zero speed flag above threshold");
  a_speed_match: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (cmd_speed_i == motor_speed_i) |=> flags_o.speed_match)
    else $error("speed match flag missing");
  a_warn_sel: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    flags_o.warn_two ==
      $past(state_i.warn_cond[warning_select_two_i]))
    else $error("warning two flag wrong");
  a_warn_one: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    flags_o.warn_one ==
      $past(state_i.warn_cond[warning_select_one_i]))
    else $error("warning one flag wrong");
  a_pcmd_flag: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(state_i.pos_cmd_in) |=> flags_o.pos_cmd)
    else $error("position command flag late");
  a_pcmd_level: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    flags_o.pos_cmd == $past(state_i.pos_cmd_in))
    else $error("position command flag wrong");
  a_vlim_flag: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (state_i.torque_mode && !state_i.speed_limit_active)
      |=> flags_o.speed_limiting)
    else $error("speed limiting flag missing");
  a_vlim_off: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (!state_i.torque_mode && !state_i.speed_limit_active)
      |=> !flags_o.speed_limiting)
    else $error("speed limiting flag stuck");
  a_alm_attr: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (!state_i.alarm_present && !state_i.alarm_clearable)
      |=> !flags_o.alarm_attr)
    else $error("alarm attribute flag stuck");
  a_alm_on: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    state_i.alarm_present |=> flags_o.alarm_attr)
    else $error("alarm attribute flag missing");
  a_vcmd_flag: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    state_i.speed_cmd_in |=> flags_o.speed_cmd)
    else $error("speed command flag missing");
  a_vcmd_off: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (!state_i.speed_mode && !state_i.speed_cmd_in)
      |=> !flags_o.speed_cmd)
    else $error("speed command flag stuck");
  a_term_none: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (output_select_first_i == sso_pkg::SEL_NONE) |=> !term_o[0])
    else $error("unrouted terminal driven");
  a_term_route: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (output_select_first_i == sso_pkg::SEL_ZSPD)
      |=> term_o[0] == flags_o.zero_speed)
    else $error("routed terminal wrong");
  a_term_illegal: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (output_select_2_i > sso_pkg::SEL_VCMD) |=> !term_o[1])
    else $error("illegal selector drives terminal");
  a_term_tlim: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (output_select_last_i == sso_pkg::SEL_TLIM)
      |=> term_o[3] == flags_o.torque_limited)
    else $error("terminal lags its flag");
  a_index_pulse: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ext_index_o |=> !ext_index_o)
    else $error("index pulse too long");
  a_quad_step: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !quad_sel |=> $stable(ext_pos_o))
    else $error("position moved while serial selected");
  a_ext_rx_mask: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !ser_sel |=> !ext_ser_rx_o)
    else $error("serial receive leaks without serial type");
  a_ext_oe: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    quad_sel |=> !ext_enc_serial_pair_oe_o)
    else $error("serial pair driven in quadrature mode");
  a_ext_quiet: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !ext_enc_serial_pair_oe_o |-> !ext_enc_serial_pair_o)
    else $error("external pair data without enable");
  a_mot_oe: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    motor_ser_tx_en_i |=> motor_enc_serial_pair_oe_o)
    else $error("motor pair not driven");
  a_mot_idle: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !motor_ser_tx_en_i |=> !motor_enc_serial_pair_oe_o)
    else $error("motor pair driven while idle");

endmodule
`default_nettype wire
